// ===== rtl/swk_status_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - GPIO wake flag bit 4, clear-on-read
// - Test pin mode level at bit 7
// - INTERRUPT_PIN_N pull-up configuration at bit 6
// - GPIO level bit 4, wake level bit 0
// - Wake level refreshes live or per cyclic sample; GPIO level live only
// - GPIO level only in wake/switch configs
// - Disabled pin function freezes its level
// - HV measurement zeroes and freezes wake and GPIO levels
// - Overcurrent flag bit 6, clear-on-read
// - One sticky overcurrent flag for both switches
// - Open-load flag bit 6, high-side only
// - Reset clears all; restart keeps some bits
// - Sync bit set after good frame
// - Bus silence bit 3 during selective wake
// - Active only without error, valid, bit2
// - Activate on mode change, never code 100
// - Wake pattern bit 1, frame bit 0
// - Bus timeout sticky after silence rises
// - System error set only while enabled
module swk_status_regs
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    input wire logic restart_i,
    // Pins
    input wire logic wake_pin_i,
    input wire logic gpio_pin_i,
    input wire logic test_pin_i,
    input wire logic interrupt_pin_n_pullup_i,
    // Operating state
    input wire swk_status_pkg::sbc_mode_t sbc_mode_i,
    input wire swk_status_pkg::gpio_cfg_t gpio_cfg_i,
    input wire logic wake_pin_enable_i,
    input wire logic cyclic_sense_i,
    input wire logic sample_evt_i,
    input wire logic hv_measure_enable_i,
    // Switch and wake events
    input wire logic gpio_wake_evt_i,
    input wire logic gpio_overcurrent_flag_evt_i,
    input wire logic gpio_openload_flag_evt_i,
    // CAN selective wake
    input wire logic [2:0] can_mode_i,
    input wire logic can_mode_wr_i,
    input wire logic config_valid_i,
    input wire logic can_frame_ok_i,
    input wire logic can_silence_i,
    input wire logic wake_pattern_i,
    input wire logic wake_frame_i,
    input wire logic swk_cfg_err_i,
    input wire logic swk_ecnt_ovf_i,
    input wire logic bus_timeout_clr_i,
    input wire logic sys_err_clr_i,
    // Register read port
    input wire logic rd_en_i,
    input wire logic [6:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // Status to other blocks
    output logic bus_timeout_o,
    output logic swk_sys_err_o,
    output logic swk_active_o,
    output logic fail_output_flag_o
);
    import swk_status_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] t);
        addr_hit = (a == t);
    endfunction

    pin_levels_if pins_if ();
    pin_sync u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pins_i({interrupt_pin_n_pullup_i, test_pin_i, gpio_pin_i, wake_pin_i}),
        .levels(pins_if.src)
    );

    logic gpio_wake_ff, oc_ff, ol_ff;
    logic test_lvl_ff, interrupt_pin_n_lvl_ff, gpio_pin_level_ff, wake_lvl_ff, fo_ff;
    logic sync_ff, silence_ff, active_ff, wup_ff, wuf_ff;
    logic timeout_ff, sys_err_ff;
    logic [2:0] can_mode_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic nxt_gpio_wake, nxt_oc, nxt_ol;
    logic nxt_test_lvl, nxt_interrupt_pin_n_lvl, nxt_gpio_pin_level, nxt_wake_lvl, nxt_fo;
    logic nxt_sync, nxt_silence, nxt_active, nxt_wup, nxt_wuf;
    logic nxt_timeout, nxt_sys_err;
    logic [2:0] nxt_can_mode;
    logic [7:0] nxt_rd_data;
    logic nxt_rd_valid;
    logic live_mode, update_en, gpio_as_io, swk_enabled, mode_change;

    // ------------------------------------------------------------------
    // Update conditions
    // ------------------------------------------------------------------
    // Cyclic sampling overrides live tracking so a sampled level is held
    assign live_mode = (sbc_mode_i == SBC_NORMAL) || (sbc_mode_i == SBC_STOP)
        || (sbc_mode_i == SBC_INIT) || (sbc_mode_i == SBC_RESTART);
    assign update_en = cyclic_sense_i ? sample_evt_i : live_mode;
    assign gpio_as_io = (gpio_cfg_i == GPIO_WAKE_IN) || (gpio_cfg_i == GPIO_LOW_SIDE)
        || (gpio_cfg_i == GPIO_HIGH_SIDE);
    assign swk_enabled = can_mode_i[CAN_MODE_SWK_BIT];
    assign mode_change = can_mode_wr_i && (can_mode_i != can_mode_ff);

    // ------------------------------------------------------------------
    // Wake source and switch fault flags
    // ------------------------------------------------------------------
    // Set beats the read clear so an event in the read cycle survives
    always_comb
    begin
        nxt_gpio_wake = gpio_wake_ff;
        nxt_oc = oc_ff;
        nxt_ol = ol_ff;
        if (rd_en_i && addr_hit(rd_addr_i, ADDR_GPIO_WAKE))
            nxt_gpio_wake = 1'b0;
        if (rd_en_i && addr_hit(rd_addr_i, ADDR_GPIO_OVERCURRENT_FLAG))
            nxt_oc = 1'b0;
        if (rd_en_i && addr_hit(rd_addr_i, ADDR_GPIO_OPENLOAD_FLAG))
            nxt_ol = 1'b0;
        if (gpio_wake_evt_i)
            nxt_gpio_wake = 1'b1;
        // Flag outlives a later reconfiguration of the switch
        if (gpio_overcurrent_flag_evt_i && ((gpio_cfg_i == GPIO_LOW_SIDE)
            || (gpio_cfg_i == GPIO_HIGH_SIDE)))
            nxt_oc = 1'b1;
        if (gpio_openload_flag_evt_i && (gpio_cfg_i == GPIO_HIGH_SIDE))
            nxt_ol = 1'b1;
        if (restart_i)
            nxt_gpio_wake = 1'b0;
        if (soft_reset_i)
        begin
            nxt_gpio_wake = 1'b0;
            nxt_oc = 1'b0;
            nxt_ol = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Input level register
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_test_lvl = pins_if.level[PIN_TEST];
        nxt_interrupt_pin_n_lvl = pins_if.level[PIN_INTERRUPT_PIN_N];
        nxt_wake_lvl = wake_lvl_ff;
        nxt_gpio_pin_level = gpio_pin_level_ff;
        nxt_fo = fo_ff;
        if (update_en && wake_pin_enable_i)
            nxt_wake_lvl = pins_if.level[PIN_WAKE];
        if (update_en && gpio_as_io && !cyclic_sense_i)
            nxt_gpio_pin_level = pins_if.level[PIN_GPIO];
        if (gpio_cfg_i == GPIO_FAIL_OUT)
            nxt_fo = pins_if.level[PIN_GPIO];
        if (hv_measure_enable_i)
        begin
            nxt_wake_lvl = 1'b0;
            nxt_gpio_pin_level = 1'b0;
        end
        if (soft_reset_i)
        begin
            nxt_wake_lvl = 1'b0;
            nxt_gpio_pin_level = 1'b0;
            nxt_test_lvl = 1'b0;
            nxt_interrupt_pin_n_lvl = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Selective wake status
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_can_mode = can_mode_wr_i ? can_mode_i : can_mode_ff;
        nxt_active = active_ff;
        if (mode_change && (can_mode_i != CAN_MODE_NO_ACT))
            nxt_active = !sys_err_ff && config_valid_i && swk_enabled;
        // Any broken precondition drops activity at once
        if (sys_err_ff || !config_valid_i || !swk_enabled)
            nxt_active = 1'b0;
        nxt_sync = active_ff && (sync_ff || can_frame_ok_i);
        nxt_silence = active_ff && can_silence_i;
        nxt_wup = wup_ff || wake_pattern_i;
        nxt_wuf = wuf_ff || wake_frame_i;
        nxt_timeout = timeout_ff;
        if (bus_timeout_clr_i)
            nxt_timeout = 1'b0;
        if (swk_enabled && nxt_silence && !silence_ff)
            nxt_timeout = 1'b1;
        nxt_sys_err = sys_err_ff;
        if (sys_err_clr_i)
            nxt_sys_err = 1'b0;
        if (swk_enabled && (swk_cfg_err_i || swk_ecnt_ovf_i))
            nxt_sys_err = 1'b1;
        if (restart_i)
            nxt_sync = 1'b0;
        if (soft_reset_i)
        begin
            nxt_active = 1'b0;
            nxt_sync = 1'b0;
            nxt_silence = 1'b0;
            nxt_wup = 1'b0;
            nxt_wuf = 1'b0;
            nxt_timeout = 1'b0;
            nxt_sys_err = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read port: data one cycle after the request
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_rd_valid = rd_en_i;
        nxt_rd_data = RST_STATUS;
        if (rd_en_i)
        begin
            unique case (rd_addr_i)
                ADDR_GPIO_WAKE: nxt_rd_data[BIT_GPIO_WAKE] = gpio_wake_ff;
                ADDR_INPUT_LEVEL:
                begin
                    nxt_rd_data[BIT_TEST_MODE] = test_lvl_ff;
                    nxt_rd_data[BIT_INTERRUPT_PIN_N_CFG] = interrupt_pin_n_lvl_ff;
                    nxt_rd_data[BIT_GPIO_PIN_LEVEL] = gpio_pin_level_ff;
                    nxt_rd_data[BIT_WAKE_LVL] = wake_lvl_ff;
                end
                ADDR_GPIO_OVERCURRENT_FLAG: nxt_rd_data[BIT_OC] = oc_ff;
                ADDR_GPIO_OPENLOAD_FLAG: nxt_rd_data[BIT_OL] = ol_ff;
                ADDR_SWK:
                begin
                    nxt_rd_data[BIT_SYNC] = sync_ff;
                    nxt_rd_data[BIT_SILENCE] = silence_ff;
                    nxt_rd_data[BIT_SWK_ACTIVE] = active_ff;
                    nxt_rd_data[BIT_WUP] = wup_ff;
                    nxt_rd_data[BIT_WUF] = wuf_ff;
                end
                default: nxt_rd_data = RST_STATUS;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State registers; power-on reset clears everything
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            gpio_wake_ff <= 1'b0;
            oc_ff <= 1'b0;
            ol_ff <= 1'b0;
            test_lvl_ff <= 1'b0;
            interrupt_pin_n_lvl_ff <= 1'b0;
            gpio_pin_level_ff <= 1'b0;
            wake_lvl_ff <= 1'b0;
            fo_ff <= 1'b0;
            sync_ff <= 1'b0;
            silence_ff <= 1'b0;
            active_ff <= 1'b0;
            wup_ff <= 1'b0;
            wuf_ff <= 1'b0;
            timeout_ff <= 1'b0;
            sys_err_ff <= 1'b0;
            can_mode_ff <= 3'h0;
            rd_data_ff <= RST_STATUS;
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            gpio_wake_ff <= nxt_gpio_wake;
            oc_ff <= nxt_oc;
            ol_ff <= nxt_ol;
            test_lvl_ff <= nxt_test_lvl;
            interrupt_pin_n_lvl_ff <= nxt_interrupt_pin_n_lvl;
            gpio_pin_level_ff <= nxt_gpio_pin_level;
            wake_lvl_ff <= nxt_wake_lvl;
            fo_ff <= nxt_fo;
            sync_ff <= nxt_sync;
            silence_ff <= nxt_silence;
            active_ff <= nxt_active;
            wup_ff <= nxt_wup;
            wuf_ff <= nxt_wuf;
            timeout_ff <= nxt_timeout;
            sys_err_ff <= nxt_sys_err;
            can_mode_ff <= nxt_can_mode;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign rd_data_o = rd_data_ff;
    assign rd_valid_o = rd_valid_ff;
    assign bus_timeout_o = timeout_ff;
    assign swk_sys_err_o = sys_err_ff;
    assign swk_active_o = active_ff;
    assign fail_output_flag_o = fo_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_wake_cor;
        rd_en_i && addr_hit(rd_addr_i, ADDR_GPIO_WAKE) && !gpio_wake_evt_i
            |=> !gpio_wake_ff;
    endproperty
    a_wake_cor: assert property (p_wake_cor) else $error("wake flag not cleared");

    property p_oc_set;
        gpio_overcurrent_flag_evt_i && (gpio_cfg_i == GPIO_LOW_SIDE) && !soft_reset_i
            |=> oc_ff ##1 (oc_ff || $past(rd_en_i) || $past(soft_reset_i));
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent not held");

    property p_ol_cause;
        $rose(ol_ff) |-> $past(gpio_openload_flag_evt_i) && $past(gpio_cfg_i) == GPIO_HIGH_SIDE;
    endproperty
    a_ol_cause: assert property (p_ol_cause) else $error("open-load without cause");

    property p_hv_zero;
        hv_measure_enable_i[*2] |=> !wake_lvl_ff && !gpio_pin_level_ff;
    endproperty
    a_hv_zero: assert property (p_hv_zero) else $error("levels not zero in HV");

    property p_gpio_frozen;
        (gpio_cfg_i == GPIO_OFF) && !hv_measure_enable_i && !soft_reset_i
            |=> $stable(gpio_pin_level_ff);
    endproperty
    a_gpio_frozen: assert property (p_gpio_frozen) else $error("gpio level moved");

    property p_active_cond;
        active_ff |-> $past(config_valid_i) && $past(swk_enabled) && !$past(sys_err_ff);
    endproperty
    a_active_cond: assert property (p_active_cond) else $error("active w/o cond");

    property p_no_act_100;
        can_mode_wr_i && (can_mode_i == CAN_MODE_NO_ACT) && !active_ff |=> !active_ff;
    endproperty
    a_no_act_100: assert property (p_no_act_100) else $error("mode 100 activated");

    property p_timeout_sticky;
        timeout_ff && !bus_timeout_clr_i && !soft_reset_i |=> timeout_ff;
    endproperty
    a_timeout_sticky: assert property (p_timeout_sticky) else $error("timeout lost");

    property p_restart_keep;
        restart_i && !soft_reset_i && oc_ff && !rd_en_i |=> oc_ff ##0 !sync_ff;
    endproperty
    a_restart_keep: assert property (p_restart_keep) else $error("restart wrong");

    property p_sync_cause;
        $rose(sync_ff) |-> $past(can_frame_ok_i) && $past(active_ff);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("sync w/o frame");

    c_read_swk: cover property (rd_en_i && rd_addr_i == ADDR_SWK ##1 rd_valid_o);
    c_activate: cover property ($rose(active_ff));
    c_timeout: cover property ($rose(timeout_ff));
    c_oc_read: cover property (oc_ff ##1 rd_en_i && rd_addr_i == ADDR_GPIO_OVERCURRENT_FLAG ##1 !oc_ff);

endmodule // swk_status_regs

`default_nettype wire

// ===== rtl/swk_status_pkg.sv
package swk_status_pkg;

    // ------------------------------------------------------------------
    // Register offsets, seven-bit serial addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_GPIO_WAKE = 7'h47;
    localparam logic [6:0] ADDR_INPUT_LEVEL = 7'h48;
    localparam logic [6:0] ADDR_GPIO_OVERCURRENT_FLAG = 7'h54;
    localparam logic [6:0] ADDR_GPIO_OPENLOAD_FLAG = 7'h55;
    localparam logic [6:0] ADDR_SWK = 7'h70;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_GPIO_WAKE = 4;
    localparam int BIT_TEST_MODE = 7;
    localparam int BIT_INTERRUPT_PIN_N_CFG = 6;
    localparam int BIT_GPIO_PIN_LEVEL = 4;
    localparam int BIT_WAKE_LVL = 0;
    localparam int BIT_OC = 6;
    localparam int BIT_OL = 6;
    localparam int BIT_SYNC = 6;
    localparam int BIT_SILENCE = 3;
    localparam int BIT_SWK_ACTIVE = 2;
    localparam int BIT_WUP = 1;
    localparam int BIT_WUF = 0;

    // ------------------------------------------------------------------
    // Reset values and mode codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [2:0] CAN_MODE_NO_ACT = 3'h4;
    localparam int CAN_MODE_SWK_BIT = 2;

    // Pin slots of the synchroniser
    localparam int PIN_COUNT = 4;
    localparam int PIN_WAKE = 0;
    localparam int PIN_GPIO = 1;
    localparam int PIN_TEST = 2;
    localparam int PIN_INTERRUPT_PIN_N = 3;

    typedef enum logic [2:0] {
        SBC_INIT = 3'h0,
        SBC_NORMAL = 3'h1,
        SBC_STOP = 3'h2,
        SBC_SLEEP = 3'h3,
        SBC_RESTART = 3'h4,
        SBC_FAIL_SAFE = 3'h5
    } sbc_mode_t;

    typedef enum logic [2:0] {
        GPIO_OFF = 3'h0,
        GPIO_FAIL_OUT = 3'h1,
        GPIO_WAKE_IN = 3'h2,
        GPIO_LOW_SIDE = 3'h3,
        GPIO_HIGH_SIDE = 3'h4
    } gpio_cfg_t;

endpackage

// ===== rtl/pin_levels_if.sv
`timescale 1ns/1ns
`default_nettype none

// Synchronised pin levels from the sampler to the register bank
interface pin_levels_if;
    logic [3:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync
    import swk_status_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Raw pins
    input wire logic [PIN_COUNT-1:0] pins_i,
    // Synchronised levels
    pin_levels_if.src levels
);

    logic [PIN_COUNT-1:0] meta_ff;
    logic [PIN_COUNT-1:0] sync_ff;
    logic [PIN_COUNT-1:0] nxt_meta;
    logic [PIN_COUNT-1:0] nxt_sync;

    // ------------------------------------------------------------------
    // Two-stage synchroniser per pin; first stage feeds only the second
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_sync
            // Next values of both stages
            always_comb
            begin
                nxt_meta[gi] = pins_i[gi];
                nxt_sync[gi] = meta_ff[gi];
            end

            // Stage registers
            always_ff @(posedge ref_clk_i)
            begin
                if (!rst_n_i)
                begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end
                else
                begin
                    meta_ff[gi] <= nxt_meta[gi];
                    sync_ff[gi] <= nxt_sync[gi];
                end
            end
        end
    endgenerate

    assign levels.level = sync_ff;

endmodule // pin_sync

`default_nettype wire

// ===== bench/host_mcu_model.sv
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------
// Host reading status bytes through the internal read strobe
// --------------------------------------------------------------
module host_mcu_model
(
    // Clock
    input wire logic ref_clk_i,
    // Read answer
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    // Read request
    output logic rd_en_o,
    output logic [6:0] rd_addr_o
);
    initial rd_en_o = 1'b0;
    initial rd_addr_o = 7'h00;

    // One read; a read of the wake, overcurrent or open-load flag register is also its clear
    task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
        @(posedge ref_clk_i);
        rd_en_o <= 1'b1;
        rd_addr_o <= addr;
        @(posedge ref_clk_i);
        // Released address is inverted so a stale value is never reused
        rd_en_o <= 1'b0;
        rd_addr_o <= ~addr;
        @(negedge ref_clk_i);
        // Missing valid pulse turns the byte unknown so it cannot match
        data = (rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
    endtask
endmodule // host_mcu_model

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import swk_status_pkg::*;

    // --------------------------------------------------------------
    // Stimulus, all changed by non-blocking assignment on rising edges
    // --------------------------------------------------------------
    localparam int EV_GWAKE = 0;
    localparam int EV_OC = 1;
    localparam int EV_OL = 2;
    localparam int EV_SAMPLE = 3;
    localparam int EV_FRAME = 4;
    localparam int EV_WUP = 5;
    localparam int EV_WUF = 6;
    localparam int EV_OVF = 7;
    localparam int EV_SOFT = 8;
    localparam int EV_RESTART = 9;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] evt = 10'h000;
    logic wake_pin = 1'b0, gpio_pin = 1'b0, test_pin = 1'b0, interrupt_pin_n_pu = 1'b0;
    sbc_mode_t sbc_mode = SBC_NORMAL;
    gpio_cfg_t gpio_cfg = GPIO_OFF;
    logic wake_en = 1'b0, cyclic = 1'b0, hv_meas = 1'b0;
    logic cfg_err = 1'b0, to_clr = 1'b0, err_clr = 1'b0;
    logic [2:0] can_mode = 3'h0;
    logic mode_wr = 1'b0, cfg_valid = 1'b0, silence = 1'b0;
    logic rd_en;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_valid, bus_timeout, sys_err, swk_active, fail_out;
    int error_cnt = 0;
    int checks = 0;

    always #25 ref_clk = ~ref_clk;

    // --------------------------------------------------------------
    // Block under test and host
    // --------------------------------------------------------------
    swk_status_regs swk_status_regs_i (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .soft_reset_i(evt[EV_SOFT]),
        .restart_i(evt[EV_RESTART]), .wake_pin_i(wake_pin), .gpio_pin_i(gpio_pin),
        .test_pin_i(test_pin), .interrupt_pin_n_pullup_i(interrupt_pin_n_pu), .sbc_mode_i(sbc_mode),
        .gpio_cfg_i(gpio_cfg), .wake_pin_enable_i(wake_en), .cyclic_sense_i(cyclic),
        .sample_evt_i(evt[EV_SAMPLE]), .hv_measure_enable_i(hv_meas),
        .gpio_wake_evt_i(evt[EV_GWAKE]), .gpio_overcurrent_flag_evt_i(evt[EV_OC]),
        .gpio_openload_flag_evt_i(evt[EV_OL]), .can_mode_i(can_mode), .can_mode_wr_i(mode_wr),
        .config_valid_i(cfg_valid), .can_frame_ok_i(evt[EV_FRAME]),
        .can_silence_i(silence), .wake_pattern_i(evt[EV_WUP]),
        .wake_frame_i(evt[EV_WUF]), .swk_cfg_err_i(cfg_err), .swk_ecnt_ovf_i(evt[EV_OVF]),
        .bus_timeout_clr_i(to_clr), .sys_err_clr_i(err_clr), .rd_en_i(rd_en),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .bus_timeout_o(bus_timeout), .swk_sys_err_o(sys_err),
        .swk_active_o(swk_active), .fail_output_flag_o(fail_out));

    host_mcu_model host_mcu_model_i (
        .ref_clk_i(ref_clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
        .rd_en_o(rd_en), .rd_addr_o(rd_addr));

    // --------------------------------------------------------------
    // Shared helpers
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host_mcu_model_i.read_reg(addr, d);
        chk($sformatf("reg %h", addr), d, exp);
    endtask

    // Single-cycle pulse on one event line
    task automatic pulse(input int idx);
        @(posedge ref_clk);
        evt[idx] <= 1'b1;
        @(posedge ref_clk);
        evt[idx] <= 1'b0;
    endtask

    task automatic write_mode(input logic [2:0] m);
        @(posedge ref_clk);
        can_mode <= m;
        mode_wr <= 1'b1;
        @(posedge ref_clk);
        mode_wr <= 1'b0;
    endtask

    // Let edges pass, then look between edges where outputs are settled
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset_values();
        logic [6:0] addrs [6] = '{ADDR_GPIO_WAKE, ADDR_INPUT_LEVEL, ADDR_GPIO_OVERCURRENT_FLAG,
                                  ADDR_GPIO_OPENLOAD_FLAG, ADDR_SWK, 7'h7F};
        foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    endtask

    task automatic t_wake_flag();
        pulse(EV_GWAKE);
        rd_chk(ADDR_GPIO_WAKE, 8'h10);
        rd_chk(ADDR_GPIO_WAKE, 8'h00);
    endtask

    task automatic t_switch_faults();
        @(posedge ref_clk);
        gpio_cfg <= GPIO_LOW_SIDE;
        pulse(EV_OC);
        @(posedge ref_clk);
        gpio_cfg <= GPIO_OFF;
        rd_chk(ADDR_GPIO_OVERCURRENT_FLAG, 8'h40);
        rd_chk(ADDR_GPIO_OVERCURRENT_FLAG, 8'h00);
        @(posedge ref_clk);
        gpio_cfg <= GPIO_HIGH_SIDE;
        pulse(EV_OC);
        pulse(EV_OL);
        rd_chk(ADDR_GPIO_OVERCURRENT_FLAG, 8'h40);
        rd_chk(ADDR_GPIO_OPENLOAD_FLAG, 8'h40);
        rd_chk(ADDR_GPIO_OPENLOAD_FLAG, 8'h00);
    endtask

    task automatic t_levels();
        @(posedge ref_clk);
        {wake_pin, gpio_pin, test_pin, interrupt_pin_n_pu, wake_en} <= 5'h1F;
        gpio_cfg <= GPIO_WAKE_IN;
        settle(5);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD1);
        @(posedge ref_clk);
        hv_meas <= 1'b1;
        settle(3);
        rd_chk(ADDR_INPUT_LEVEL, 8'hC0);
        @(posedge ref_clk);
        hv_meas <= 1'b0;
        settle(3);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD1);
        // Fail-output pin state goes to its own flag, level bit freezes
        @(posedge ref_clk);
        gpio_cfg <= GPIO_FAIL_OUT;
        wake_en <= 1'b0;
        wake_pin <= 1'b0;
        settle(5);
        chk("fail_out", {7'h00, fail_out}, 8'h01);
        @(posedge ref_clk);
        gpio_pin <= 1'b0;
        settle(5);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD1);
        // Cyclic sense: level moves only on a sampling event
        @(posedge ref_clk);
        cyclic <= 1'b1;
        wake_en <= 1'b1;
        settle(5);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD1);
        pulse(EV_SAMPLE);
        settle(2);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD0);
        // Sleep mode without cyclic sense holds the stored level
        @(posedge ref_clk);
        cyclic <= 1'b0;
        sbc_mode <= SBC_SLEEP;
        wake_pin <= 1'b1;
        settle(5);
        rd_chk(ADDR_INPUT_LEVEL, 8'hD0);
    endtask

    task automatic t_selective_wake();
        write_mode(3'h6);
        settle(2);
        chk("swk_active", {7'h00, swk_active}, 8'h00);
        @(posedge ref_clk);
        cfg_valid <= 1'b1;
        write_mode(3'h4);
        settle(2);
        chk("swk_active", {7'h00, swk_active}, 8'h00);
        write_mode(3'h5);
        settle(2);
        chk("swk_active", {7'h00, swk_active}, 8'h01);
        pulse(EV_FRAME);
        @(posedge ref_clk);
        silence <= 1'b1;
        settle(2);
        rd_chk(ADDR_SWK, 8'h4C);
        chk("bus_timeout", {7'h00, bus_timeout}, 8'h01);
        @(posedge ref_clk);
        silence <= 1'b0;
        settle(2);
        rd_chk(ADDR_SWK, 8'h44);
        chk("bus_timeout", {7'h00, bus_timeout}, 8'h01);
        pulse(EV_WUP);
        pulse(EV_WUF);
        rd_chk(ADDR_SWK, 8'h47);
        pulse(EV_RESTART);
        rd_chk(ADDR_SWK, 8'h07);
        pulse(EV_OVF);
        settle(2);
        chk("sys_err", {7'h00, sys_err}, 8'h01);
        rd_chk(ADDR_SWK, 8'h03);
        // Clear strobes, then a configuration error sets the error again
        @(posedge ref_clk);
        err_clr <= 1'b1;
        to_clr <= 1'b1;
        @(posedge ref_clk);
        err_clr <= 1'b0;
        to_clr <= 1'b0;
        settle(1);
        chk("sys_err", {7'h00, sys_err}, 8'h00);
        chk("bus_timeout", {7'h00, bus_timeout}, 8'h00);
        @(posedge ref_clk);
        cfg_err <= 1'b1;
        @(posedge ref_clk);
        cfg_err <= 1'b0;
        settle(1);
        chk("sys_err", {7'h00, sys_err}, 8'h01);
        pulse(EV_SOFT);
        rd_chk(ADDR_SWK, 8'h00);
        chk("bus_timeout", {7'h00, bus_timeout}, 8'h00);
    endtask

    task automatic t_restart_keeps();
        @(posedge ref_clk);
        gpio_cfg <= GPIO_LOW_SIDE;
        pulse(EV_OC);
        pulse(EV_GWAKE);
        pulse(EV_RESTART);
        rd_chk(ADDR_GPIO_OVERCURRENT_FLAG, 8'h40);
        rd_chk(ADDR_GPIO_WAKE, 8'h00);
        pulse(EV_OC);
        pulse(EV_SOFT);
        rd_chk(ADDR_GPIO_OVERCURRENT_FLAG, 8'h00);
    endtask

    // --------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // --------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_wake_flag();
        t_switch_faults();
        t_levels();
        t_selective_wake();
        t_restart_keeps();
        conclude();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end
endmodule // tb_top

`default_nettype wire
